// ==== hw/udi_frame_tick.sv ====
// Purpose: local frame tick locked to received frame starts
// Assumes: sof is a one-cycle pulse on mclk
// Notes: period counts are parameters so a bench can shorten them
`timescale 1ns/1ps
`include "udi_regs.svh"
module udi_frame_tick import udi_pkg::*; #(
    parameter int unsigned FS_CYCLES = `UDI_FS_FRAME_CYC,
    parameter int unsigned HS_CYCLES = `UDI_HS_FRAME_CYC
) (
    input wire logic mclk, // device clock
    input wire logic reset, // async reset, active high
    udi_tick_if.gen tk // frame start in, tick out
);
    logic [16:0] count_q;
    logic tick_q;
    logic [16:0] period_m1;

    // reload value follows the current speed
    assign period_m1 = tk.high_speed ? 17'(HS_CYCLES - 1) : 17'(FS_CYCLES - 1);
    assign tk.tick = tick_q;

    // countdown restarted by every received frame start
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_q <= 17'(FS_CYCLES - 1); // first tick one full-speed frame after reset
            tick_q <= 1'b0;
        end else if (tk.sof) begin
            count_q <= period_m1; // [R09]
            tick_q <= 1'b0;
        end else if (count_q == 17'h0_0000) begin
            count_q <= period_m1;
            tick_q <= 1'b1; // [R09]
        end else begin
            count_q <= count_q - 17'h0_0001;
            tick_q <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    AST_TICK_NOT_ON_SOF: assert property (tk.sof |=> !tick_q) // [R09]
        else $error("tick issued right after a frame start");
    AST_TICK_RELOAD: assert property (tick_q |-> count_q == $past(period_m1)) // [R09]
        else $error("tick without period reload");
endmodule

// ==== hw/udi_pkg.sv ====
// Purpose: shared types of the interrupt status block
// Assumes: nothing
// Notes: numbers live in udi_regs.svh
package udi_pkg;
    // host port access state
    typedef enum logic [1:0] {
        UDI_IDLE = 2'b00,
        UDI_READ = 2'b01,
        UDI_WRITE = 2'b10
    } udi_port_state_t;
endpackage

// ==== hw/udi_regs.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the interrupt status block
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef UDI_REGS_SVH
`define UDI_REGS_SVH

// register offsets on the parallel host port
`define UDI_INT_STATUS_OFS 8'h18
`define UDI_CHIP_IDENTIFICATION_OFS 8'h70

// interrupt status field positions
`define UDI_BIT_USB_RESET 0
`define UDI_BIT_SOF 1
`define UDI_BIT_FRAME_TICK 2
`define UDI_BIT_SLEEP 3
`define UDI_BIT_RESUME 4
`define UDI_BIT_HIGH_SPEED 5
`define UDI_BIT_DMA 6
`define UDI_BIT_CTRL_SETUP 8
`define UDI_BIT_CTRL_OUT 10
`define UDI_BIT_CTRL_IN 11
`define UDI_BIT_EP_BASE 12

// defined flag bits, reset value and chip_identification width
`define UDI_DEFINED_MASK 32'h03FF_FD7F
`define UDI_INT_RESET 32'h0000_0000
`define UDI_CHIP_IDENTIFICATION_W 24

// frame tick timing
`define UDI_CLK_PERIOD_NS 8
`define UDI_FS_FRAME_NS 1000000
`define UDI_HS_FRAME_NS 125000
`define UDI_FS_FRAME_CYC (`UDI_FS_FRAME_NS / `UDI_CLK_PERIOD_NS)
`define UDI_HS_FRAME_CYC (`UDI_HS_FRAME_NS / `UDI_CLK_PERIOD_NS)

`endif

// ==== hw/udi_status_top.sv ====
// Purpose: interrupt status word, interrupt pin and id register behind the parallel host port
// Assumes: event inputs are one-cycle pulses or levels on mclk; host pins are asynchronous
// Notes: host pins pass two flip-flops; data, address stable while a strobe is low
//
// Function
// R01 - host writes zeros into the six top bits of the status word
// R02 - endpoint n sets transmit flag at bit 2n+11, receive flag at 2n+10
// R03 - control endpoint sets bit 11 for transmit data, bit 10 for receive data
// R04 - control request token sets bit 8; bit 9 has no function
// R05 - change of DMA status sets bit 6; bit 7 has no function
// R06 - move to high speed sets bit 5; full-speed sleep does not
// R07 - bus leaving sleep sets bit 4
// R08 - bus entering sleep sets bit 3
// R09 - local frame tick, 1 ms full speed, 125 us high speed, sets bit 2
// R10 - received frame start sets bit 1
// R11 - USB bus reset sets bit 0
// R12 - read-only three-byte id register: part code above, revision below
// R13 - host firmware reads the id to learn which features exist
// R14 - interrupt output active while any status bit is set
// R15 - writing one clears a flag; DMA also needs its reason bit cleared
// R16 - status word at 18H, four bytes, cleared by power-on and bus reset
// R17 - flags stay set until cleared; a same-cycle event beats the clear
`timescale 1ns/1ps
`include "udi_regs.svh"
module udi_status_top import udi_pkg::*; #(
    parameter int unsigned FS_CYCLES = `UDI_FS_FRAME_CYC, // full-speed tick period
    parameter int unsigned HS_CYCLES = `UDI_HS_FRAME_CYC, // high-speed tick period
    parameter logic [15:0] PART_CODE = 16'hA5C3, // arbitrary value
    parameter logic [7:0] REVISION = 8'h01, // arbitrary value
    parameter int unsigned DMA_W = 8 // width of the DMA status word
) (
    input wire logic mclk, // device clock
    input wire logic reset, // async reset, active high
    input wire logic cs_n, // host chip select pin
    input wire logic rd_n, // host read strobe pin
    input wire logic wr_n, // host write strobe pin
    input wire logic [7:0] addr, // host address pins
    input wire logic [31:0] data_in, // host data pins, input side
    output logic [31:0] data_out, // host data pins, output side
    output logic data_oe_n, // low while driving the data pins
    output logic int_out, // interrupt to host, active high
    input wire logic [7:1] endpoint_in_buffer_event, // per-endpoint transmit events
    input wire logic [7:1] endpoint_out_buffer_event, // per-endpoint receive events
    input wire logic control_in_data_event, // control transmit buffer event
    input wire logic control_out_data_event, // control receive buffer event
    input wire logic control_request_received, // control request token pulse
    input wire logic [DMA_W-1:0] dma_status, // DMA status word
    input wire logic high_speed_mode, // level: link runs at high speed
    input wire logic bus_sleep, // level: bus is suspended
    input wire logic sof_received, // frame start packet pulse
    input wire logic usb_reset_seen // bus reset detected pulse
);
    // rising edge of a level against its previous value
    function automatic logic rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    udi_tick_if tk_if ();
    udi_port_state_t port_q;
    logic [2:0] strb_s1_q;
    logic [2:0] strb_s2_q;
    logic [7:0] addr_s1_q;
    logic [7:0] addr_s2_q;
    logic [31:0] data_s1_q;
    logic [31:0] data_s2_q;
    logic rd_prev_q;
    logic wr_prev_q;
    logic rd_on;
    logic wr_on;
    logic rd_start;
    logic wr_start;
    logic [DMA_W-1:0] dma_prev_q;
    logic hs_prev_q;
    logic sleep_prev_q;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] rdata;
    logic [31:0] data_out_q;
    logic data_oe_n_q;
    logic int_q;

    // frame tick generator
    assign tk_if.sof = sof_received;
    assign tk_if.high_speed = high_speed_mode;

    udi_frame_tick #(
        .FS_CYCLES(FS_CYCLES),
        .HS_CYCLES(HS_CYCLES)
    ) u_tick (
        .mclk(mclk),
        .reset(reset),
        .tk(tk_if.gen)
    );

    // two-stage synchronisers for every host pin
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            strb_s1_q <= 3'h7;
            strb_s2_q <= 3'h7;
            addr_s1_q <= 8'h00;
            addr_s2_q <= 8'h00;
            data_s1_q <= 32'h0000_0000;
            data_s2_q <= 32'h0000_0000;
        end else begin
            strb_s1_q <= {cs_n, rd_n, wr_n};
            strb_s2_q <= strb_s1_q;
            addr_s1_q <= addr;
            addr_s2_q <= addr_s1_q;
            data_s1_q <= data_in;
            data_s2_q <= data_s1_q;
        end
    end

    // strobe decode and start edges
    assign rd_on = ~strb_s2_q[2] & ~strb_s2_q[1];
    assign wr_on = ~strb_s2_q[2] & ~strb_s2_q[0];
    assign rd_start = rise(rd_on, rd_prev_q) & (port_q == UDI_IDLE);
    assign wr_start = rise(wr_on, wr_prev_q) & (port_q == UDI_IDLE);

    // previous strobe levels
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else begin
            rd_prev_q <= rd_on;
            wr_prev_q <= wr_on;
        end
    end

    // host port state: one access per strobe assertion
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            port_q <= UDI_IDLE;
        end else begin
            case (port_q)
                UDI_IDLE: begin
                    if (rd_start) begin
                        port_q <= UDI_READ;
                    end else if (wr_start) begin
                        port_q <= UDI_WRITE;
                    end
                end
                UDI_READ: begin
                    if (!rd_on) begin
                        port_q <= UDI_IDLE;
                    end
                end
                UDI_WRITE: begin
                    if (!wr_on) begin
                        port_q <= UDI_IDLE;
                    end
                end
                default: begin
                    port_q <= UDI_IDLE;
                end
            endcase
        end
    end

    // read decode; unmapped offsets read zero
    always_comb begin
        rdata = 32'h0000_0000;
        case (addr_s2_q)
            `UDI_INT_STATUS_OFS: begin
                rdata = status_q;
            end
            `UDI_CHIP_IDENTIFICATION_OFS: begin
                rdata = {8'h00, PART_CODE, REVISION}; // [R12]
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    // read data latched at the strobe edge, driven while the strobe stays low
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            data_out_q <= 32'h0000_0000;
            data_oe_n_q <= 1'b1;
        end else begin
            if (rd_start) begin
                data_out_q <= rdata;
            end
            data_oe_n_q <= ~(rd_start | ((port_q == UDI_READ) & rd_on));
        end
    end

    // history of levels that raise flags on a change; no reset on purpose, so
    // these follow the inputs through reset and no false edge appears after it
    always_ff @(posedge mclk) begin
        dma_prev_q <= dma_status;
        hs_prev_q <= high_speed_mode;
        sleep_prev_q <= bus_sleep;
    end

    // flag set sources
    always_comb begin
        set_vec = 32'h0000_0000;
        for (int n = 1; n < 8; n++) begin
            set_vec[`UDI_BIT_EP_BASE + 2 * n - 1] = endpoint_in_buffer_event[n]; // [R02]
            set_vec[`UDI_BIT_EP_BASE + 2 * n - 2] = endpoint_out_buffer_event[n]; // [R02]
        end
        set_vec[`UDI_BIT_CTRL_IN] = control_in_data_event; // [R03]
        set_vec[`UDI_BIT_CTRL_OUT] = control_out_data_event; // [R03]
        set_vec[`UDI_BIT_CTRL_SETUP] = control_request_received; // [R04]
        set_vec[`UDI_BIT_DMA] = (dma_status != dma_prev_q); // [R05]
        set_vec[`UDI_BIT_HIGH_SPEED] = rise(high_speed_mode, hs_prev_q); // [R06]
        set_vec[`UDI_BIT_RESUME] = rise(sleep_prev_q, bus_sleep); // [R07]
        set_vec[`UDI_BIT_SLEEP] = rise(bus_sleep, sleep_prev_q); // [R08]
        set_vec[`UDI_BIT_FRAME_TICK] = tk_if.tick | sof_received; // [R09]
        set_vec[`UDI_BIT_SOF] = sof_received; // [R10]
        set_vec[`UDI_BIT_USB_RESET] = usb_reset_seen; // [R11]
    end

    // write-one-to-clear at the status offset; reserved bits ignored
    assign clr_vec = (wr_start && addr_s2_q == `UDI_INT_STATUS_OFS)
        ? (data_s2_q & `UDI_DEFINED_MASK) : 32'h0000_0000; // [R15] [R01]

    // next status: set beats clear, bus reset wipes older flags
    always_comb begin
        if (usb_reset_seen) begin
            status_d = set_vec & `UDI_DEFINED_MASK; // [R16]
        end else begin
            status_d = ((status_q & ~clr_vec) | set_vec) & `UDI_DEFINED_MASK; // [R17]
        end
    end

    // status word and interrupt pin
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            status_q <= `UDI_INT_RESET; // [R16]
            int_q <= 1'b0;
        end else begin
            status_q <= status_d;
            int_q <= |status_d; // [R14]
        end
    end

    assign data_out = data_out_q;
    assign data_oe_n = data_oe_n_q;
    assign int_out = int_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence s_read_start;
        rd_start && addr_s2_q == `UDI_CHIP_IDENTIFICATION_OFS;
    endsequence

    sequence s_id_driven;
        !data_oe_n_q && data_out_q == {8'h00, PART_CODE, REVISION};
    endsequence

    AST_INT_LEVEL: assert property (int_q == (status_q != 32'h0000_0000)) // [R14]
        else $error("interrupt pin disagrees with status word");
    AST_RESERVED_ZERO: assert property ((status_q & ~`UDI_DEFINED_MASK) == 32'h0) // [R16]
        else $error("reserved status bit set");
    AST_EP3_IN: assert property (endpoint_in_buffer_event[3] |=> status_q[17]) // [R02]
        else $error("endpoint 3 transmit flag not set");
    AST_EP7_OUT: assert property (endpoint_out_buffer_event[7] |=> status_q[24]) // [R02]
        else $error("endpoint 7 receive flag not set");
    AST_CTRL_IN: assert property (control_in_data_event |=> status_q[11]) // [R03]
        else $error("control transmit flag not set");
    AST_SETUP: assert property (control_request_received |=> status_q[8]) // [R04]
        else $error("control request flag not set");
    AST_DMA: assert property (dma_status != $past(dma_status) |=> status_q[6]) // [R05]
        else $error("dma change flag not set");
    AST_HS: assert property ($rose(high_speed_mode) |=> status_q[5]) // [R06]
        else $error("high speed flag not set");
    AST_RESUME: assert property ($fell(bus_sleep) |=> status_q[4]) // [R07]
        else $error("resume flag not set");
    AST_SLEEP: assert property ($rose(bus_sleep) |=> status_q[3]) // [R08]
        else $error("sleep flag not set");
    AST_FRAME_TICK: assert property (tk_if.tick |=> status_q[2]) // [R09]
        else $error("frame tick flag not set");
    AST_SOF: assert property (sof_received |=> status_q[1] && status_q[2]) // [R10]
        else $error("frame start flags not set");
    AST_BUS_RESET: assert property (usb_reset_seen && !control_request_received
        |=> status_q[0] && !status_q[8]) // [R11]
        else $error("bus reset flag wrong");
    AST_ID_READ: assert property (s_read_start |=> s_id_driven) // [R12]
        else $error("id register read wrong");
    AST_W1C: assert property (clr_vec[0] && !usb_reset_seen |=> !status_q[0]) // [R15]
        else $error("write one did not clear flag");
    AST_STICKY: assert property (status_q[1] && !clr_vec[1] |=> status_q[1]) // [R17]
        else $error("flag dropped without clear");
    AST_SET_WINS: assert property (clr_vec[8] && control_request_received |=> status_q[8]) // [R17]
        else $error("event lost against clear");
    // per-source set and clear checks
    AST_CTRL_OUT: assert property (control_out_data_event |=> status_q[10]) // [R03]
        else $error("control receive flag not set");
    AST_EP1_IN: assert property (endpoint_in_buffer_event[1] |=> status_q[13]) // [R02]
        else $error("endpoint 1 transmit flag not set");
    AST_EP1_OUT: assert property (endpoint_out_buffer_event[1] |=> status_q[12]) // [R02]
        else $error("endpoint 1 receive flag not set");
    AST_EP7_IN: assert property (endpoint_in_buffer_event[7] |=> status_q[25]) // [R02]
        else $error("endpoint 7 transmit flag not set");
    AST_CLR_IN: assert property (clr_vec[11] && !control_in_data_event |=> !status_q[11]) // [R15]
        else $error("control transmit flag not cleared");
endmodule

// ==== hw/udi_tick_if.sv ====
// Purpose: carries frame start, speed and tick between top and tick generator
// Assumes: single clock mclk
// Notes: none
`timescale 1ns/1ps
interface udi_tick_if;
    logic sof;
    logic high_speed;
    logic tick;
    modport gen (input sof, input high_speed, output tick);
    modport user (output sof, output high_speed, input tick);
endinterface

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench of the interrupt status word and id register
// Assumes: frame tick periods shortened to 400 and 100 cycles
// Notes: bit 2 runs on its own, so it is masked except in the tick tests, the first read and the frame start case
`timescale 1ns/1ps
`include "udi_regs.svh"
module tb_top import udi_pkg::*;;
    localparam logic [15:0] PART = 16'h3C5A; // arbitrary value
    localparam logic [7:0] REV = 8'h02; // arbitrary value
    localparam logic [7:0] ST = `UDI_INT_STATUS_OFS;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    localparam logic [31:0] NO_TICK = 32'hFFFF_FFFB;
    localparam logic [31:0] CLR = 32'h03FF_FFFF;
    logic mclk, reset, cs_n, rd_n, wr_n, data_oe_n, int_out;
    logic [7:0] addr;
    logic [31:0] data_in, data_out;
    logic [7:1] ep_in, ep_out;
    logic ctl_in, ctl_out, ctl_req, hs, sleep, sof, busrst;
    logic [7:0] dma;
    int err_total, num_checks;

    udi_status_top #(.FS_CYCLES(400), .HS_CYCLES(100), .PART_CODE(PART), .REVISION(REV),
        .DMA_W(8)) dut (.mclk(mclk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .int_out(int_out), .endpoint_in_buffer_event(ep_in),
        .endpoint_out_buffer_event(ep_out), .control_in_data_event(ctl_in),
        .control_out_data_event(ctl_out), .control_request_received(ctl_req),
        .dma_status(dma), .high_speed_mode(hs), .bus_sleep(sleep), .sof_received(sof),
        .usb_reset_seen(busrst));

    udi_host_model host (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

    // clock, 8 ns period
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // read a register and compare under a mask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] d;
        host.read(a, d);
        check(d & m, exp & m);
    endtask

    // raise one event source for a cycle; levels keep their new value
    task automatic fire(input int k);
        @(posedge mclk);
        case (k)
            0: busrst <= 1'b1;
            1: sof <= 1'b1;
            2: hs <= 1'b0;
            3: sleep <= 1'b1;
            4: sleep <= 1'b0;
            5: hs <= 1'b1;
            6: dma <= dma + 8'h01;
            8: ctl_req <= 1'b1;
            10: ctl_out <= 1'b1;
            11: ctl_in <= 1'b1;
            default: begin
                if (k % 2 == 1) ep_in[(k - 10) / 2] <= 1'b1;
                else ep_out[(k - 10) / 2] <= 1'b1;
            end
        endcase
        @(posedge mclk);
        {busrst, sof, ctl_req, ctl_out, ctl_in} <= 5'h00;
        ep_in <= 7'h00;
        ep_out <= 7'h00;
    endtask

    // verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // hang guard, several times the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        results();
    end

    // test sequence
    initial begin
        err_total = 0;
        num_checks = 0;
        reset = 1'b1;
        {ep_in, ep_out} = 14'h0000;
        {ctl_in, ctl_out, ctl_req, hs, sleep, sof, busrst} = 7'h00;
        dma = 8'h00;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        rd_chk(ST, `UDI_INT_RESET, ALL);
        rd_chk(`UDI_CHIP_IDENTIFICATION_OFS, {8'h00, PART, REV}, ALL);
        host.write(`UDI_CHIP_IDENTIFICATION_OFS, CLR);
        rd_chk(`UDI_CHIP_IDENTIFICATION_OFS, {8'h00, PART, REV}, ALL);
        rd_chk(8'h40, 32'h0000_0000, ALL);
        // pin follows the word: frame start restarts the tick so it stays quiet
        fire(1);
        host.write(ST, CLR);
        repeat (2) @(posedge mclk);
        check({31'h0, int_out}, 32'h0000_0000);
        fire(8);
        repeat (2) @(posedge mclk);
        check({31'h0, int_out}, 32'h0000_0001);
        // every source alone sets exactly its own bit; frame start also sets bit 2
        for (int k = 0; k < 26; k++) begin
            if (k == 2 || k == 7 || k == 9) continue;
            host.write(ST, CLR);
            fire(k);
            rd_chk(ST, (k == 1) ? 32'h6 : (32'h1 << k), (k == 1) ? ALL : NO_TICK);
        end
        host.write(ST, CLR);
        fire(2);
        rd_chk(ST, 32'h0, NO_TICK);
        // event held through a clear survives it
        @(posedge mclk);
        ctl_req <= 1'b1;
        host.write(ST, CLR);
        ctl_req <= 1'b0;
        rd_chk(ST, 32'h100, NO_TICK);
        host.write(ST, CLR);
        rd_chk(ST, 32'h0, NO_TICK);
        // bus reset wipes other flags
        fire(11);
        fire(12);
        fire(0);
        rd_chk(ST, 32'h1, NO_TICK);
        // local tick at full speed, 400 cycles after a frame start
        fire(1);
        host.write(ST, CLR);
        rd_chk(ST, 32'h0, 32'h6);
        repeat (360) @(posedge mclk);
        rd_chk(ST, 32'h0, 32'h6);
        repeat (5) @(posedge mclk);
        rd_chk(ST, 32'h4, 32'h6);
        // local tick at high speed, 100 cycles
        fire(5);
        fire(1);
        host.write(ST, CLR);
        rd_chk(ST, 32'h0, 32'h6);
        repeat (60) @(posedge mclk);
        rd_chk(ST, 32'h0, 32'h6);
        repeat (5) @(posedge mclk);
        rd_chk(ST, 32'h4, 32'h6);
        // reset in mid-run clears flags
        fire(8);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd_chk(ST, 32'h0, NO_TICK);
        check({31'h0, int_out}, 32'h0000_0000);
        results();
    end
endmodule

// ==== testbench/udi_host_model.sv ====
// Purpose: host processor on the parallel port, reads and clears the status word
// Assumes: strobes low and high for six mclk cycles each, well above the four needed
// Notes: pins it releases show the inverse of their last value
`timescale 1ns/1ps
module udi_host_model (
    input wire logic mclk, // device clock
    output logic cs_n, // chip select
    output logic rd_n, // read strobe
    output logic wr_n, // write strobe
    output logic [7:0] addr, // byte address
    output logic [31:0] data_in, // write data
    input wire logic [31:0] data_out, // read data from device
    input wire logic data_oe_n // low while device drives
);
    // idle pins at time zero
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 8'h00;
        data_in = 32'h0000_0000;
    end

    // one access; read data taken while strobe still low, three cycles after it settled
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(posedge mclk);
        cs_n <= 1'b0;
        rd_n <= wr;
        wr_n <= !wr;
        addr <= a;
        data_in <= d & 32'h03FF_FFFF; // top six bits always written as zero
        repeat (6) @(posedge mclk);
        q = data_oe_n ? 32'hXXXX_XXXX : data_out; // undriven bus never matches
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        addr <= ~a;
        data_in <= ~d;
        repeat (6) @(posedge mclk);
    endtask

    // register read
    task automatic read(input logic [7:0] a, output logic [31:0] q);
        access(1'b0, a, 32'h0000_0000, q);
    endtask

    // register write; ones clear flags
    task automatic write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        access(1'b1, a, d, unused);
    endtask
endmodule
